// [shared/anpr_pkg.sv]
// Package: register map, field layout and carrier types of the negotiation page registers
package anpr_pkg;

  // Register indices; the APB byte address is four times the index
  localparam logic [9:0] ANPR_IDX_CONTROL  = 10'h200;
  localparam logic [9:0] ANPR_IDX_STATUS   = 10'h201;
  localparam logic [9:0] ANPR_IDX_LBP_LOW  = 10'h202;
  localparam logic [9:0] ANPR_IDX_LBP_MID  = 10'h203;
  localparam logic [9:0] ANPR_IDX_LBP_HIGH = 10'h204;
  localparam logic [9:0] ANPR_IDX_PBP_LOW  = 10'h205;
  localparam logic [9:0] ANPR_IDX_PBP_MID  = 10'h206;
  localparam logic [9:0] ANPR_IDX_PBP_HIGH = 10'h207;
  localparam logic [9:0] ANPR_IDX_NP_HDR   = 10'h208;
  localparam logic [9:0] ANPR_IDX_NP_CODE  = 10'h209;
  localparam logic [9:0] ANPR_IDX_IRQ_STAT = 10'h210;
  localparam logic [9:0] ANPR_IDX_IRQ_MASK = 10'h211;

  // Control register fields
  localparam int ANPR_CTL_SOFT_RESET = 15;
  localparam int ANPR_CTL_ENABLE     = 12;
  localparam int ANPR_CTL_RESTART    = 9;
  localparam logic [15:0] ANPR_CTL_RESET = 16'h1000;

  // Status register fields
  localparam int ANPR_STA_PAGE    = 6;
  localparam int ANPR_STA_DONE    = 5;
  localparam int ANPR_STA_FAULT   = 4;
  localparam int ANPR_STA_CAPABLE = 3;
  localparam int ANPR_STA_LINK    = 2;
  localparam logic [15:0] ANPR_STA_RESET = 16'h0008;

  // Local base page low word: bit 14 (acknowledge) is fixed at zero
  localparam logic [15:0] ANPR_LBP_LOW_RESET = 16'h0001;
  localparam logic [15:0] ANPR_LBP_LOW_WMASK = 16'hBFFF;
  localparam logic [15:0] ANPR_WORD_RESET    = 16'h0000;

  // Next page header: bit 14 reserved, bit 11 toggle driven by the engine
  localparam logic [15:0] ANPR_NP_HDR_WMASK = 16'hB7FF;
  localparam int          ANPR_NP_TOGGLE    = 11;

  // Interrupt status and mask layout
  localparam int ANPR_IRQ_PAGE  = 0;
  localparam int ANPR_IRQ_FAULT = 1;
  localparam int ANPR_IRQ_DONE  = 2;
  localparam int ANPR_IRQ_LINK  = 3;
  localparam logic [3:0] ANPR_IRQ_RESET = 4'h0;

  // Events and state reported by the negotiation engine
  typedef struct packed {
    logic        page_arrived;    // One-cycle pulse
    logic        far_fault;       // One-cycle pulse
    logic        done;            // Level
    logic        link_up;         // Level
    logic        partner_valid;   // One-cycle pulse, qualifies partner_page
    logic [47:0] partner_page;
    logic        toggle;          // Level
  } anpr_engine_t;

  // Controls and advertised pages driven to the negotiation engine
  typedef struct packed {
    logic        soft_reset;      // One-cycle pulse
    logic        enable;          // Level
    logic        restart;         // One-cycle pulse
    logic [47:0] local_page;
    logic [15:0] next_page_header;
    logic [15:0] next_page_code;
  } anpr_ctrl_t;

endpackage

// [rtl/anpr_regs.sv]
// APB register bank of the negotiation function with page exchange and interrupt
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps

module anpr_regs
  import anpr_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  output logic               irq,
  input  wire anpr_engine_t  engine,
  output anpr_ctrl_t         ctrl
);

  // Merge the enabled low byte lanes of a write into the old value
  function automatic logic [15:0] lane_merge(input logic [15:0] old_val,
                                             input logic [15:0] new_val,
                                             input logic [1:0]  strb);
    lane_merge = {strb[1] ? new_val[15:8] : old_val[15:8],
                  strb[0] ? new_val[7:0]  : old_val[7:0]};
  endfunction

  // Sticky flag: set wins over clear
  function automatic logic sticky(input logic cur, input logic set, input logic clr);
    sticky = set | (cur & ~clr);
  endfunction

  logic        enable_ff;
  logic        soft_reset_ff;
  logic        restart_ff;
  logic        page_ff;
  logic        fault_ff;
  logic        link_ff;
  logic        link_prev_ff;
  logic        done_prev_ff;
  logic [15:0] lbp_low_ff;
  logic [15:0] lbp_mid_ff;
  logic [15:0] lbp_high_ff;
  logic [47:0] pbp_ff;
  logic [15:0] np_hdr_ff;
  logic [15:0] np_code_ff;
  logic [3:0]  irq_stat_ff;
  logic [3:0]  irq_mask_ff;
  logic [31:0] prdata_ff;

  // Address decode
  wire logic [9:0]  idx       = paddr[11:2];
  wire logic        aligned   = (paddr[1:0] == 2'h0);
  wire logic        hit       = aligned &&
                                ((idx >= ANPR_IDX_CONTROL && idx <= ANPR_IDX_NP_CODE) ||
                                 idx == ANPR_IDX_IRQ_STAT || idx == ANPR_IDX_IRQ_MASK);
  wire logic        access    = psel & penable;
  wire logic        wr        = access & pwrite & hit;
  wire logic        setup_rd  = psel & ~penable & ~pwrite;
  wire logic [15:0] wd        = pwdata[15:0];

  wire logic wr_ctl   = wr && idx == ANPR_IDX_CONTROL;
  wire logic wr_sta   = wr && idx == ANPR_IDX_STATUS;
  wire logic wr_lbpl  = wr && idx == ANPR_IDX_LBP_LOW;
  wire logic wr_lbpm  = wr && idx == ANPR_IDX_LBP_MID;
  wire logic wr_lbph  = wr && idx == ANPR_IDX_LBP_HIGH;
  wire logic wr_nph   = wr && idx == ANPR_IDX_NP_HDR;
  wire logic wr_npc   = wr && idx == ANPR_IDX_NP_CODE;
  wire logic wr_mask  = wr && idx == ANPR_IDX_IRQ_MASK;
  wire logic rd_istat = access & ~pwrite & aligned & (idx == ANPR_IDX_IRQ_STAT);

  // Written values after byte lane merge; unwritten lanes keep old contents
  wire logic [15:0] ctl_now = {soft_reset_ff, 2'b00, enable_ff, 2'b00, restart_ff, 9'h000};
  wire logic [15:0] sta_now;
  wire logic [15:0] ctl_wd  = lane_merge(ctl_now, wd, pstrb[1:0]);
  wire logic [15:0] sta_wd  = lane_merge(sta_now, wd, pstrb[1:0]);

  // Control register
  wire logic nxt_enable     = wr_ctl ? ctl_wd[ANPR_CTL_ENABLE] : enable_ff;
  wire logic nxt_soft_reset = wr_ctl & pstrb[1] & wd[ANPR_CTL_SOFT_RESET];
  wire logic nxt_restart    = wr_ctl & pstrb[1] & wd[ANPR_CTL_RESTART] &
                              nxt_enable & ~nxt_soft_reset;

  // Status flags; a written one leaves a clear-by-zero flag alone
  wire logic page_clr    = (wr_sta & ~sta_wd[ANPR_STA_PAGE]) | soft_reset_ff;
  wire logic fault_clr   = (wr_sta & ~sta_wd[ANPR_STA_FAULT]) | soft_reset_ff;
  wire logic nxt_page    = sticky(page_ff, engine.page_arrived, page_clr);
  wire logic nxt_fault   = sticky(fault_ff, engine.far_fault, fault_clr);
  wire logic link_chg    = engine.link_up != link_prev_ff;
  wire logic link_wr0    = wr_sta & ~sta_wd[ANPR_STA_LINK];
  wire logic nxt_link    = link_chg ? engine.link_up :
                           (link_wr0 ? 1'b1 : link_ff);
  wire logic done_rise   = engine.done & ~done_prev_ff;

  assign sta_now = {9'h000, page_ff, engine.done, fault_ff, 1'b1, link_ff, 2'b00};

  // Interrupt status: read clears, a new event in the same cycle wins
  wire logic [3:0] irq_evt;
  assign irq_evt[ANPR_IRQ_PAGE]  = engine.page_arrived;
  assign irq_evt[ANPR_IRQ_FAULT] = engine.far_fault;
  assign irq_evt[ANPR_IRQ_DONE]  = done_rise;
  assign irq_evt[ANPR_IRQ_LINK]  = link_chg;
  wire logic [3:0] nxt_irq_stat  = irq_evt | (irq_stat_ff & {4{~rd_istat}});
  wire logic [15:0] mask_wd      = lane_merge({12'h000, irq_mask_ff}, wd, pstrb[1:0]);
  wire logic [3:0]  nxt_irq_mask = wr_mask ? mask_wd[3:0] : irq_mask_ff;

  // Page words; the partner page is loaded by the engine, the others by writes
  wire logic [15:0] lbpl_wd     = lane_merge(lbp_low_ff, wd, pstrb[1:0]);
  wire logic [15:0] nxt_lbp_low = wr_lbpl ? (lbpl_wd & ANPR_LBP_LOW_WMASK)
                                          : lbp_low_ff;
  wire logic [15:0] nxt_lbp_mid = wr_lbpm ? lane_merge(lbp_mid_ff, wd, pstrb[1:0])
                                          : lbp_mid_ff;
  wire logic [15:0] nxt_lbp_hi  = wr_lbph ? lane_merge(lbp_high_ff, wd, pstrb[1:0])
                                          : lbp_high_ff;
  wire logic [15:0] nph_wd      = lane_merge(np_hdr_ff, wd, pstrb[1:0]);
  wire logic [15:0] nxt_np_hdr  = wr_nph ? (nph_wd & ANPR_NP_HDR_WMASK)
                                         : np_hdr_ff;
  wire logic [15:0] nxt_np_code = wr_npc ? lane_merge(np_code_ff, wd, pstrb[1:0])
                                         : np_code_ff;
  wire logic [47:0] nxt_pbp     = soft_reset_ff ? 48'h0000_0000_0000 :
                                  (engine.partner_valid ? engine.partner_page : pbp_ff);

  // Next page header as read: toggle bit comes from the engine
  wire logic [15:0] np_hdr_rd = np_hdr_ff |
                                ({15'h0000, engine.toggle} << ANPR_NP_TOGGLE);

  // Read selection
  logic [15:0] rd_word;
  always_comb begin
    unique case (idx)
      ANPR_IDX_CONTROL:  rd_word = ctl_now;
      ANPR_IDX_STATUS:   rd_word = sta_now;
      ANPR_IDX_LBP_LOW:  rd_word = lbp_low_ff;
      ANPR_IDX_LBP_MID:  rd_word = lbp_mid_ff;
      ANPR_IDX_LBP_HIGH: rd_word = lbp_high_ff;
      ANPR_IDX_PBP_LOW:  rd_word = pbp_ff[15:0];
      ANPR_IDX_PBP_MID:  rd_word = pbp_ff[31:16];
      ANPR_IDX_PBP_HIGH: rd_word = pbp_ff[47:32];
      ANPR_IDX_NP_HDR:   rd_word = np_hdr_rd;
      ANPR_IDX_NP_CODE:  rd_word = np_code_ff;
      ANPR_IDX_IRQ_STAT: rd_word = {12'h000, irq_stat_ff};
      ANPR_IDX_IRQ_MASK: rd_word = {12'h000, irq_mask_ff};
      default:           rd_word = 16'h0000;
    endcase
  end
  wire logic [31:0] nxt_prdata = (setup_rd & hit) ? {16'h0000, rd_word} : prdata_ff;

  // Control register flops

  // Negotiation enable; comes out of reset set
  // so that negotiation runs without software help
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      enable_ff <= ANPR_CTL_RESET[ANPR_CTL_ENABLE];
    end else begin
      enable_ff <= nxt_enable;
    end
  end

  // Soft reset pulse; lasts one cycle, so the
  // control bit reads back zero right after it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      soft_reset_ff <= 1'b0;
    end else begin
      soft_reset_ff <= nxt_soft_reset;
    end
  end

  // Restart pulse; refused while disabled or
  // while a soft reset is requested in the same write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      restart_ff <= 1'b0;
    end else begin
      restart_ff <= nxt_restart;
    end
  end

  // Status flags

  // Page received flag; an arriving page
  // beats a software clear in the same cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      page_ff <= ANPR_STA_RESET[ANPR_STA_PAGE];
    end else begin
      page_ff <= nxt_page;
    end
  end

  // Far fault flag; a new fault beats
  // a software clear in the same cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fault_ff <= ANPR_STA_RESET[ANPR_STA_FAULT];
    end else begin
      fault_ff <= nxt_fault;
    end
  end

  // Link bit; follows every engine change,
  // a written zero forces it up between changes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      link_ff <= ANPR_STA_RESET[ANPR_STA_LINK];
    end else begin
      link_ff <= nxt_link;
    end
  end

  // Last link level, for change detection;
  // resets to the idle (down) level, so no false change
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      link_prev_ff <= 1'b0;
    end else begin
      link_prev_ff <= engine.link_up;
    end
  end

  // Last done level, for the rising edge event;
  // resets low so reset alone raises no event
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      done_prev_ff <= 1'b0;
    end else begin
      done_prev_ff <= engine.done;
    end
  end

  // Page words

  // Local base page low word; the acknowledge
  // bit is masked off on every write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lbp_low_ff <= ANPR_LBP_LOW_RESET;
    end else begin
      lbp_low_ff <= nxt_lbp_low;
    end
  end

  // Local base page middle word
  // (nonce and low technology abilities)
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lbp_mid_ff <= ANPR_WORD_RESET;
    end else begin
      lbp_mid_ff <= nxt_lbp_mid;
    end
  end

  // Local base page high word
  // (upper technology abilities)
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lbp_high_ff <= ANPR_WORD_RESET;
    end else begin
      lbp_high_ff <= nxt_lbp_hi;
    end
  end

  // Next page header; the reserved bit and the
  // toggle bit are never stored here
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      np_hdr_ff <= ANPR_WORD_RESET;
    end else begin
      np_hdr_ff <= nxt_np_hdr;
    end
  end

  // First unformatted code word
  // of the next page
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      np_code_ff <= ANPR_WORD_RESET;
    end else begin
      np_code_ff <= nxt_np_code;
    end
  end

  // Partner base page, captured whole when the
  // engine qualifies it, zeroed by a soft reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pbp_ff <= {3{ANPR_WORD_RESET}};
    end else begin
      pbp_ff <= nxt_pbp;
    end
  end

  // Interrupt and read data

  // Interrupt status; a read clears it, but an
  // event in the clearing cycle is kept
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_stat_ff <= ANPR_IRQ_RESET;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
    end
  end

  // Interrupt mask, same layout as the status;
  // all sources masked out of reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_mask_ff <= ANPR_IRQ_RESET;
    end else begin
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  // Read data, loaded in the setup cycle so it
  // stands for the whole access cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata_ff <= 32'h0000_0000;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

  // APB answers in the first access cycle; read data was loaded in setup
  assign pready  = 1'b1;
  assign pslverr = access & ~hit;
  assign prdata  = prdata_ff;
  assign irq     = |(irq_stat_ff & irq_mask_ff);

  assign ctrl.soft_reset       = soft_reset_ff;
  assign ctrl.enable           = enable_ff;
  assign ctrl.restart          = restart_ff;
  assign ctrl.local_page       = {lbp_high_ff, lbp_mid_ff, lbp_low_ff};
  assign ctrl.next_page_header = np_hdr_rd;
  assign ctrl.next_page_code   = np_code_ff;

endmodule

// [testbench/anpr_engine_model.sv]
// Behavioural far-side negotiation engine feeding events and pages to the register bank
`timescale 1ns/1ps
module anpr_engine_model import anpr_pkg::*; (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire anpr_ctrl_t  ctrl,
  input  wire logic [3:0]  ev_bits,
  input  wire logic [47:0] page_val,
  output anpr_engine_t     engine
);
  // Bits: page pulse, fault pulse, done level, link level; idle page lines scramble
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      engine <= '0;
    end else begin
      engine.page_arrived  <= ev_bits[3];
      engine.partner_valid <= ev_bits[3];
      engine.far_fault     <= ev_bits[2];
      engine.done          <= ev_bits[1] && ctrl.enable && !ctrl.soft_reset;
      engine.link_up       <= ev_bits[0];
      engine.toggle        <= engine.toggle ^ ev_bits[3];
      engine.partner_page  <= ev_bits[3] ? page_val : ~engine.partner_page;
    end
  end
endmodule

// [testbench/anpr_regs_chk.sv]
// Port-level assertions for the negotiation page register bank
`timescale 1ns/1ps
module anpr_regs_chk import anpr_pkg::*; (
  input wire logic         clk,
  input wire logic         reset,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [11:0]  paddr,
  input wire logic [31:0]  pwdata,
  input wire logic [3:0]   pstrb,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire logic         irq,
  input wire anpr_engine_t engine,
  input wire anpr_ctrl_t   ctrl
);
  logic wr_full, wr_ctl;
  assign wr_full = psel && penable && pwrite && pready && (pstrb[1:0] == 2'b11);
  assign wr_ctl  = wr_full && (paddr == 12'h800);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_soft_pulse: assert property (
    wr_ctl && pwdata[15] |=> ctrl.soft_reset ##1 !ctrl.soft_reset) else $error("soft reset pulse");
  chk_restart_pulse: assert property (
    wr_ctl && pwdata[12] && pwdata[9] && !pwdata[15] |=> ctrl.restart ##1 !ctrl.restart)
    else $error("restart pulse");
  chk_restart_refused: assert property (
    wr_ctl && !pwdata[12] |=> !ctrl.restart) else $error("restart while disabled");
  chk_status_fixed: assert property (
    psel && penable && !pwrite && paddr == 12'h804 |-> prdata[3] && prdata[31:7] == 25'h0
    && prdata[1:0] == 2'h0) else $error("status fixed bits");
  chk_local_low: assert property (
    wr_full && paddr == 12'h808 |=> ctrl.local_page[15:0] == ($past(pwdata[15:0]) & 16'hBFFF))
    else $error("local page low word");
  chk_local_upper: assert property (
    wr_full && paddr == 12'h810 |=> ctrl.local_page[47:32] == $past(pwdata[15:0]))
    else $error("local page high word");
  chk_np_fields: assert property (
    ctrl.next_page_header[11] == engine.toggle && !ctrl.next_page_header[14])
    else $error("next page toggle");
  chk_bad_align: assert property (
    psel && penable && paddr[1:0] != 2'h0 |-> pslverr) else $error("misaligned not refused");
endmodule
bind anpr_regs anpr_regs_chk u_chk (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq), .engine(engine), .ctrl(ctrl));

// [testbench/tb_top.sv]
// Directed bench for the negotiation page register bank with a behavioural far side
`timescale 1ns/1ps
module tb_top
  import anpr_pkg::*;
();
  logic         clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]  paddr = 12'h0;
  logic [31:0]  pwdata = 32'h0;
  logic [3:0]   pstrb = 4'hF, ev_bits = 4'h0;
  logic [47:0]  page_val = 48'h1234_5678_9ABC;
  logic [31:0]  prdata;
  logic         pready, pslverr, irq;
  anpr_engine_t engine;
  anpr_ctrl_t   ctrl;
  int           error_cnt = 0, total_checks = 0;
  // Step word: op nibble, byte address, value; op 0 read and compare, 1 write,
  // 2 far-side event bits, 3 compare irq level, 4 write that must be refused
  logic [31:0]  steps [$] = '{
    32'h0800_1000, 32'h0804_0008, 32'h0808_0001, 32'h080C_0000, 32'h0810_0000,
    32'h0814_0000, 32'h0818_0000, 32'h081C_0000, 32'h0820_0000, 32'h0824_0000,
    32'h0840_0000, 32'h0844_0000, 32'h1808_FFFF, 32'h0808_BFFF, 32'h180C_FFFF,
    32'h080C_FFFF, 32'h1810_FFFF, 32'h0810_FFFF, 32'h1814_FFFF, 32'h0814_0000,
    32'h1818_FFFF, 32'h0818_0000, 32'h181C_FFFF, 32'h081C_0000, 32'h1820_FFFF,
    32'h0820_B7FF, 32'h1824_FFFF, 32'h0824_FFFF, 32'h4828_0000, 32'h4802_0000,
    32'h1800_9200, 32'h0800_1000, 32'h1800_0200, 32'h0800_0000, 32'h1800_1200,
    32'h0800_1000, 32'h2000_0008, 32'h0814_9ABC, 32'h0818_5678, 32'h081C_1234,
    32'h0820_BFFF, 32'h0804_0048, 32'h2000_0004, 32'h0804_0058, 32'h1804_FFFF,
    32'h0804_0058, 32'h2000_0001, 32'h0804_005C, 32'h2000_0000, 32'h0804_0058,
    32'h1804_0000, 32'h0804_000C, 32'h2000_0002, 32'h0804_002C, 32'h2000_0000,
    32'h0804_000C, 32'h2000_0008, 32'h1800_9000, 32'h0814_0000, 32'h0804_000C,
    32'h0820_B7FF, 32'h0840_000F, 32'h0840_0000, 32'h1844_0001, 32'h0844_0001,
    32'h2000_0004, 32'h3000_0000, 32'h0840_0002, 32'h0840_0000, 32'h2000_0008,
    32'h3000_0001, 32'h0840_0001, 32'h2000_0000, 32'h3000_0000};
  anpr_regs u_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .engine(engine), .ctrl(ctrl));
  anpr_engine_model u_far (.clk(clk), .reset(reset), .ctrl(ctrl), .ev_bits(ev_bits),
    .page_val(page_val), .engine(engine));
  initial forever #2.5 clk = ~clk;
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) error_cnt++;
    if (seen !== exp) $display("wrong value %s expected %h seen %h", nm, exp, seen);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Pulses drop after one cycle, levels stay; then let status settle
  task automatic ev(input logic [3:0] b);
    @(posedge clk);
    ev_bits <= b;
    @(posedge clk);
    ev_bits <= b & 4'h3;
    repeat (3) @(posedge clk);
  endtask
  task automatic xfer(input logic [3:0] op, input logic [11:0] ad, input logic [15:0] v);
    int n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= (op != 4'h0);
    paddr  <= ad;
    pwdata <= {16'hFFFF, v};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) error_cnt++;
    if (pready !== 1'b1) tally_and_finish();
    if (op == 4'h0) check("read data", prdata, {16'h0, v});
    check("error response", {31'h0, pslverr}, {31'h0, op == 4'h4});
  endtask
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    foreach (steps[i]) begin
      if (steps[i][31:28] == 4'h2) ev(steps[i][3:0]);
      else if (steps[i][31:28] == 4'h3)
        check("irq", {31'h0, irq}, {31'h0, steps[i][0]});
      else xfer(steps[i][31:28], steps[i][27:16], steps[i][15:0]);
    end
    tally_and_finish();
  end
endmodule
